// ---- include/lss_pkg.sv ----
// Constants and types shared by the LED sink protection sequencer.
//--------------------------------------------------------------------
//--------------------------------------------------------------------
package lss_pkg;
   localparam int CLK_MHZ = 250;
   localparam int NCH = 4;
   localparam int T_SHDN_MS = 32;
   localparam int T_CHECK_US = 256;
   localparam int T_SOFT_MS = 128;
   localparam int T_BLANK_MS = 32;
   localparam int T_EDGE_US = 4;
   localparam int T_OPEN_US = 20;
   localparam int T_SHORT_US = 2;
   localparam int SHDN_CYC = T_SHDN_MS * 1000 * CLK_MHZ;
   localparam int CHECK_CYC = T_CHECK_US * CLK_MHZ;
   localparam int SOFT_CYC = T_SOFT_MS * 1000 * CLK_MHZ;
   localparam int BLANK_CYC = T_BLANK_MS * 1000 * CLK_MHZ;
   localparam int EDGE_CYC = T_EDGE_US * CLK_MHZ;
   localparam int OPEN_CYC = T_OPEN_US * CLK_MHZ;
   localparam int SHORT_CYC = T_SHORT_US * CLK_MHZ;
   // Register byte offsets.
   localparam logic [7:0] OFS_IRQ_STAT = 8'h00;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;
   // Interrupt bit positions.
   localparam int IRQ_OPEN = 0;
   localparam int IRQ_SHORT = 1;
   localparam int IRQ_OTP = 2;
   localparam int IRQ_SHDN = 3;
   localparam int NIRQ = 4;
   // Status field positions.
   localparam int ST_STATE = 0;
   localparam int ST_UNUSED = 8;
   localparam int ST_FAULT_N = 12;
   localparam logic [3:0] CTRL_RST = 4'hF;
   typedef enum logic [5:0] {
      LSS_OFF = 6'h01,
      LSS_CHECK = 6'h02,
      LSS_SOFT = 6'h04,
      LSS_BLANK = 6'h08,
      LSS_RUN = 6'h10,
      LSS_FAULT = 6'h20
   } lss_state_e;
endpackage : lss_pkg

// ---- sim/led_sink_protection_sequencer_tb_top.sv ----
// Self-checking bench for the LED sink protection sequencer.
`timescale 1ns/1ps
module led_sink_protection_sequencer_tb_top;
   import lss_pkg::*;
   localparam int SH = 50;
   localparam int CK = 20;
   localparam int SS = 40;
   localparam int BL = 30;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ce = 1'b1, en_pwm = 1'b0, uvlo = 1'b0;
   logic otp_hot = 1'b0, short_cmd = 1'b0, prev;
   logic pready, pslverr, feedback_output, fault_n, irq, ssi, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, lf = 32'h20;
   logic [NCH-1:0] sink_on, chan_float, cs_low, open_cmd = 4'h0;
   int n_errors = 0, num_checks = 0, cycles = 0;
   always #2 pclk = ~pclk;
   lss_sequencer #(.SHDN_N(SH), .CHECK_N(CK), .SOFT_N(SS), .BLANK_N(BL),
      .OPEN_N(12), .EDGE_N(4), .SHORT_N(3)) i_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .en_pwm(en_pwm), .uvlo(uvlo), .otp_hot(otp_hot),
      .chan_float(chan_float), .cs_low(cs_low), .short_sense_input(ssi),
      .sink_on(sink_on), .feedback_output(feedback_output),
      .fault_n(fault_n), .irq(irq));
   lss_led_model i_led (.open_cmd(open_cmd), .short_cmd(short_cmd),
      .sink_on(sink_on), .chan_float(chan_float), .cs_low(cs_low),
      .short_sense_input(ssi));
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         give_verdict();
      end
   end
   //------------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------------
   task automatic give_verdict();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] exp_st(input logic [5:0] s,
      input logic [3:0] u, input logic f);
      return {19'h0, f, u, 2'b00, s};
   endfunction : exp_st
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic pulse(input int hi, input int lo);
      @(posedge pclk);
      en_pwm <= 1'b1;
      repeat (hi) @(posedge pclk);
      en_pwm <= 1'b0;
      repeat (lo - 1) @(posedge pclk);
      @(negedge pclk);
   endtask : pulse
   // Walks check, soft start and duty-gated blanking into run.
   task automatic power_up(input logic flt);
      @(posedge pclk);
      en_pwm <= 1'b1;
      short_cmd <= flt;
      repeat (CK) @(posedge pclk);
      @(negedge pclk);
      check(feedback_output === 1'b0, "feedback early");
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check(feedback_output === 1'b1, "feedback low");
      repeat (SS) @(posedge pclk);
      repeat (2 * BL - 11) @(posedge pclk) en_pwm <= ~en_pwm;
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd === exp_st(6'h08, 4'h8, 1'b1), "blank ended");
      en_pwm <= 1'b1;
      short_cmd <= 1'b0;
      repeat (10) @(posedge pclk);
      en_pwm <= 1'b0;
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd === exp_st(6'h10, 4'h8, 1'b1), "no run");
   endtask : power_up
   //------------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd === exp_st(6'h01, 4'h0, 1'b1), "status reset");
      apb(1'b0, OFS_CTRL, 32'h0);
      check(rd === 32'h0000000F, "ctrl reset");
      apb(1'b0, 8'h10, 32'h0);
      check(err === 1'b1 && rd === 32'h0, "unmapped");
      apb(1'b1, OFS_IRQ_MASK, 32'h0000000F);
      power_up(1'b1);
      $display("Test power-up done");
      prev = en_pwm;
      repeat (60)
      begin
         lf = lfsr_next(lf);
         @(posedge pclk);
         en_pwm <= lf[0];
         @(negedge pclk);
         check(sink_on === ({4{prev}} & 4'h7), "sink dim");
         prev = en_pwm;
      end
      $display("Test dimming done");
      @(posedge pclk);
      en_pwm <= 1'b0;
      open_cmd <= 4'h1;
      repeat (3) @(posedge pclk);
      repeat (2) pulse(8, 4);
      check(fault_n === 1'b1, "open early");
      repeat (2) pulse(8, 4);
      check(fault_n === 1'b0 && irq === 1'b1, "no open fault");
      @(posedge pclk);
      en_pwm <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check(sink_on === 4'h0, "sinks on in fault");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(rd[IRQ_OPEN] === 1'b1, "open irq");
      apb(1'b1, OFS_IRQ_STAT, 32'h0000000F);
      @(negedge pclk);
      check(irq === 1'b0, "irq not cleared");
      @(posedge pclk);
      en_pwm <= 1'b0;
      repeat (SH - 20) @(posedge pclk);
      en_pwm <= 1'b1;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      check(fault_n === 1'b0, "fault left early");
      @(posedge pclk);
      en_pwm <= 1'b0;
      repeat (SH + 5) @(posedge pclk);
      @(negedge pclk);
      check(fault_n === 1'b1, "fault kept");
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[5:0] === 6'h01, "no shutdown");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(rd[IRQ_SHDN] === 1'b1, "shutdown irq");
      $display("Test open fault done");
      open_cmd <= 4'h0;
      power_up(1'b0);
      short_cmd <= 1'b1;
      pulse(6, 4);
      check(fault_n === 1'b1, "short early");
      repeat (2) pulse(6, 4);
      check(fault_n === 1'b0, "no short fault");
      @(posedge pclk);
      uvlo <= 1'b1;
      short_cmd <= 1'b0;
      repeat (2) @(posedge pclk);
      uvlo <= 1'b0;
      @(negedge pclk);
      check(fault_n === 1'b1 && sink_on === 4'h0, "uvlo");
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[5:0] === 6'h01, "uvlo state");
      $display("Test short and uvlo done");
      power_up(1'b0);
      en_pwm <= 1'b1;
      otp_hot <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check(sink_on === 4'h0 && fault_n === 1'b0, "hot");
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(rd[IRQ_OTP] === 1'b1, "hot irq");
      otp_hot <= 1'b0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      check(sink_on === 4'h7 && fault_n === 1'b1, "cooled");
      $display("Test thermal done");
      @(posedge pclk);
      ce <= 1'b0;
      en_pwm <= 1'b0;
      repeat (SH + 5) @(posedge pclk);
      @(negedge pclk);
      check(sink_on === 4'h7, "ce did not freeze sinks");
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[5:0] === 6'h10, "ce did not freeze state");
      ce <= 1'b1;
      $display("Test clock enable done");
      give_verdict();
   end
endmodule : led_sink_protection_sequencer_tb_top

// ---- sim/lss_led_model.sv ----
// Behavioural LED strings and sense comparators seen by the sinks.
`timescale 1ns/1ps
module lss_led_model
   import lss_pkg::*;
#(
   parameter logic [NCH-1:0] UNUSED = 4'h8
)
(
   // Fault commands from the bench
   input wire logic [NCH-1:0] open_cmd,
   input wire logic short_cmd,
   // Device side
   input wire logic [NCH-1:0] sink_on,
   output logic [NCH-1:0] chan_float,
   output logic [NCH-1:0] cs_low,
   output logic short_sense_input
);
   // An unused, open or idle string leaves its sense pin low.
   assign chan_float = UNUSED;
   assign cs_low = UNUSED | open_cmd | ~sink_on;
   assign short_sense_input = short_cmd & (|sink_on);
endmodule : lss_led_model

// ---- verilog/lss_sequencer.sv ----
// Power-on sequencer and open/short/thermal protection core.
`timescale 1ns/1ps
module lss_sequencer
   import lss_pkg::*;
#(
   parameter int unsigned SHDN_N = SHDN_CYC,
   parameter int unsigned CHECK_N = CHECK_CYC,
   parameter int unsigned SOFT_N = SOFT_CYC,
   parameter int unsigned BLANK_N = BLANK_CYC,
   parameter int unsigned OPEN_N = OPEN_CYC,
   parameter int unsigned EDGE_N = EDGE_CYC,
   parameter int unsigned SHORT_N = SHORT_CYC
)
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog flags
   input wire logic en_pwm,
   input wire logic uvlo,
   input wire logic otp_hot,
   input wire logic [NCH-1:0] chan_float,
   input wire logic [NCH-1:0] cs_low,
   input wire logic short_sense_input,
   // Outputs
   output logic [NCH-1:0] sink_on,
   output logic feedback_output,
   output logic fault_n,
   output logic irq
);
   lss_state_e state_q;
   logic en_d1_q;
   logic [31:0] low_cnt_q;
   logic [31:0] phase_cnt_q;
   logic [31:0] edge_cnt_q;
   logic [31:0] open_cnt_q;
   logic [31:0] short_cnt_q;
   logic [NCH-1:0] unused_q;
   logic [NCH-1:0] ctrl_q;
   logic [NIRQ-1:0] stat_q;
   logic [NIRQ-1:0] mask_q;
   logic [31:0] prdata_q;
   logic [NCH-1:0] sink_q;
   logic fb_q;
   logic fault_n_q;
   logic en_rise;
   logic shdn_hit;
   logic det_en;
   logic open_cond;
   logic short_cond;
   logic open_hit;
   logic short_hit;
   logic wr;
   logic [NIRQ-1:0] ev;

   //-----------------------------------------------------------------
   // Phase sequencing
   //-----------------------------------------------------------------
   assign en_rise = en_pwm && !en_d1_q;
   assign shdn_hit = !en_pwm && (low_cnt_q == SHDN_N - 1);
   // The rise cycle itself is blanked, while the sinks are still off.
   assign det_en = (state_q == LSS_RUN) && (edge_cnt_q == 32'h0) &&
      !en_rise && !otp_hot;
   assign open_cond = en_pwm && |(cs_low & ~unused_q);
   assign short_cond = en_pwm && short_sense_input;
   assign open_hit = det_en && open_cond && (open_cnt_q == OPEN_N - 1);
   assign short_hit = det_en && short_cond && (short_cnt_q == SHORT_N - 1);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_d1_q <= 1'b0;
         low_cnt_q <= 32'h0;
      end
      else if (ce)
      begin
         en_d1_q <= en_pwm && !uvlo;
         if (uvlo || en_pwm || shdn_hit)
            low_cnt_q <= 32'h0;
         else
            low_cnt_q <= low_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= LSS_OFF;
         phase_cnt_q <= 32'h0;
      end
      else if (ce)
      begin
         if (uvlo || shdn_hit)
         begin
            state_q <= LSS_OFF;
            phase_cnt_q <= 32'h0;
         end
         else
         begin
            unique case (state_q)
               LSS_OFF:
                  if (en_pwm)
                  begin
                     state_q <= LSS_CHECK;
                     phase_cnt_q <= 32'h0;
                  end
               LSS_CHECK:
                  if (phase_cnt_q == CHECK_N - 1)
                  begin
                     state_q <= LSS_SOFT;
                     phase_cnt_q <= 32'h0;
                  end
                  else
                     phase_cnt_q <= phase_cnt_q + 32'h1;
               LSS_SOFT:
                  if (phase_cnt_q == SOFT_N - 1)
                  begin
                     state_q <= LSS_BLANK;
                     phase_cnt_q <= 32'h0;
                  end
                  else
                     phase_cnt_q <= phase_cnt_q + 32'h1;
               LSS_BLANK:
                  if (en_pwm)
                  begin
                     if (phase_cnt_q == BLANK_N - 1)
                     begin
                        state_q <= LSS_RUN;
                        phase_cnt_q <= 32'h0;
                     end
                     else
                        phase_cnt_q <= phase_cnt_q + 32'h1;
                  end
               LSS_RUN:
                  if (open_hit || short_hit)
                     state_q <= LSS_FAULT;
               LSS_FAULT:
                  state_q <= LSS_FAULT;
               default:
                  state_q <= LSS_OFF;
            endcase
         end
      end
   end

   // Channels that float during the check phase stay marked unused.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         unused_q <= '0;
      else if (ce)
      begin
         if (uvlo || state_q == LSS_OFF)
            unused_q <= '0;
         else if (state_q == LSS_CHECK)
            unused_q <= unused_q | chan_float;
      end
   end

   //-----------------------------------------------------------------
   // Fault detection counters
   //-----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         edge_cnt_q <= 32'h0;
      else if (ce)
      begin
         if (uvlo || state_q == LSS_OFF)
            edge_cnt_q <= 32'h0;
         else if (en_rise)
            edge_cnt_q <= EDGE_N - 32'h1;
         else if (edge_cnt_q != 32'h0)
            edge_cnt_q <= edge_cnt_q - 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         open_cnt_q <= 32'h0;
         short_cnt_q <= 32'h0;
      end
      else if (ce)
      begin
         if (uvlo || state_q != LSS_RUN)
         begin
            open_cnt_q <= 32'h0;
            short_cnt_q <= 32'h0;
         end
         else if (det_en)
         begin
            if (open_cond)
               open_cnt_q <= open_cnt_q + 32'h1;
            if (short_cond)
               short_cnt_q <= short_cnt_q + 32'h1;
         end
      end
   end

   //-----------------------------------------------------------------
   // Sink, feedback and fault outputs
   //-----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sink_q <= '0;
         fb_q <= 1'b0;
         fault_n_q <= 1'b1;
      end
      else if (ce)
      begin
         fb_q <= !uvlo && state_q == LSS_SOFT;
         fault_n_q <= !(!uvlo && (state_q == LSS_FAULT || otp_hot &&
            state_q != LSS_OFF));
         if (uvlo || otp_hot || open_hit || short_hit || !en_pwm ||
            !(state_q inside {LSS_SOFT, LSS_BLANK, LSS_RUN}))
            sink_q <= '0;
         else
            sink_q <= ctrl_q & ~unused_q;
      end
   end

   assign sink_on = sink_q;
   assign feedback_output = fb_q;
   assign fault_n = fault_n_q;

   //-----------------------------------------------------------------
   // APB registers and interrupt
   //-----------------------------------------------------------------
   assign wr = psel && penable && pwrite;
   assign ev[IRQ_OPEN] = ce && !uvlo && state_q == LSS_RUN && open_hit;
   assign ev[IRQ_SHORT] = ce && !uvlo && state_q == LSS_RUN && short_hit;
   assign ev[IRQ_OTP] = ce && otp_hot && !uvlo && state_q != LSS_OFF;
   assign ev[IRQ_SHDN] = ce && !uvlo && shdn_hit && state_q != LSS_OFF;

   // A new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat_q <= '0;
      else if (wr && paddr == OFS_IRQ_STAT)
         stat_q <= (stat_q & ~pwdata[NIRQ-1:0]) | ev;
      else
         stat_q <= stat_q | ev;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_q <= '0;
         ctrl_q <= CTRL_RST;
      end
      else if (wr && paddr == OFS_IRQ_MASK)
         mask_q <= pwdata[NIRQ-1:0];
      else if (wr && paddr == OFS_CTRL)
         ctrl_q <= pwdata[NCH-1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0;
      else if (psel && !penable)
      begin
         prdata_q <= 32'h0;
         unique case (paddr)
            OFS_IRQ_STAT: prdata_q[NIRQ-1:0] <= stat_q;
            OFS_IRQ_MASK: prdata_q[NIRQ-1:0] <= mask_q;
            OFS_STATUS:
            begin
               prdata_q[ST_STATE +: 6] <= state_q;
               prdata_q[ST_UNUSED +: NCH] <= unused_q;
               prdata_q[ST_FAULT_N] <= fault_n_q;
            end
            OFS_CTRL: prdata_q[NCH-1:0] <= ctrl_q;
            default: prdata_q <= 32'h0;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(paddr inside
      {OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_STATUS, OFS_CTRL});
   assign irq = |(stat_q & mask_q);

   //-----------------------------------------------------------------
   // Assertions
   //-----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_short_trip;
      ce && !uvlo && state_q == LSS_RUN && short_hit;
   endsequence

   sequence s_latched;
      state_q == LSS_FAULT && !fault_n && sink_on == '0;
   endsequence

   sequence s_open_trip;
      ce && !uvlo && state_q == LSS_RUN && open_hit;
   endsequence

   sequence s_off_entry;
      ce && (uvlo || shdn_hit) ##1 ce;
   endsequence

   AST_SHDN: assert property (ce && !uvlo && shdn_hit |=>
      state_q == LSS_OFF) else $error("shutdown not taken");
   AST_UVLO_OFF: assert property (ce && uvlo |=>
      sink_on == '0 && state_q == LSS_OFF) else $error("uvlo not off");
   AST_SINK_EN: assert property (|sink_on && $past(ce) |->
      $past(en_pwm)) else $error("sink on with dim low");
   AST_RESTART: assert property (ce && !uvlo && state_q == LSS_OFF
      && en_pwm |=> state_q == LSS_CHECK) else $error("no restart");
   AST_CHECK_LEN: assert property (state_q == LSS_CHECK |->
      phase_cnt_q < CHECK_N) else $error("check phase too long");
   AST_SOFT_FB: assert property (ce && !uvlo && state_q == LSS_SOFT
      |=> feedback_output) else $error("feedback not forced");
   AST_NO_DET: assert property (ce && state_q != LSS_RUN |=>
      open_cnt_q == 32'h0 && short_cnt_q == 32'h0)
      else $error("detector active early");
   AST_EDGE_BLANK: assert property (ce && en_rise && !uvlo &&
      state_q != LSS_OFF |=> !det_en) else $error("edge blank missed");
   AST_SHORT_LATCH: assert property (s_short_trip ##1 ce && !uvlo
      && !shdn_hit |=> s_latched) else $error("short not latched");
   AST_OTP: assert property (ce && otp_hot && !uvlo &&
      state_q != LSS_OFF |=> !fault_n && sink_on == '0)
      else $error("otp not handled");
   AST_DIM_OFF: assert property (ce && !en_pwm |=>
      sink_on == '0) else $error("sink on after dim low");
   AST_BLANK_GATE: assert property (ce && !uvlo && !shdn_hit &&
      state_q == LSS_BLANK && !en_pwm |=> state_q == LSS_BLANK &&
      $stable(phase_cnt_q)) else $error("blank counted dim low");
   AST_RUN_ENTRY: assert property (ce && !uvlo && !shdn_hit &&
      state_q == LSS_BLANK && en_pwm && phase_cnt_q == BLANK_N - 1
      |=> state_q == LSS_RUN) else $error("run not entered");
   AST_OPEN_CNT: assert property (ce && !uvlo && det_en && open_cond
      |=> open_cnt_q == $past(open_cnt_q) + 32'h1)
      else $error("open counter stalled");
   AST_OPEN_LATCH: assert property (s_open_trip ##1 ce && !uvlo
      && !shdn_hit |=> s_latched) else $error("open not latched");
   AST_SHORT_CNT: assert property (ce && !uvlo && det_en && short_cond
      |=> short_cnt_q == $past(short_cnt_q) + 32'h1)
      else $error("short counter stalled");
   AST_FAULT_HOLD: assert property (ce && !uvlo && !shdn_hit &&
      state_q == LSS_FAULT |=> state_q == LSS_FAULT)
      else $error("fault released early");
   AST_CNT_CLEAR: assert property (s_off_entry |=>
      open_cnt_q == 32'h0 && short_cnt_q == 32'h0)
      else $error("counters not cleared");
   AST_UNUSED_OFF: assert property ((sink_on & unused_q) == '0)
      else $error("unused channel on");
endmodule : lss_sequencer
